// ===== bench/cvd_grabber_model.sv
// cvd_grabber_model: far-side grabber that drives the control lines.
// assumes the bench asks for one trigger pulse at a time.
`default_nettype none
module cvd_grabber_model (
	input wire logic fire1_i,
	input wire logic fire2_i,
	output logic cc1_o,
	output logic cc2_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lclk;
	// link clock offset so it never lines up with the pixel clock
	initial begin
		lclk = 1'b0;
		#13;
		forever #200 lclk = ~lclk;
	end
	// lines rest low; each request becomes one pulse
	always @(posedge lclk) begin
		cc1_o <= fire1_i;
		cc2_o <= fire2_i;
	end
endmodule
`default_nettype wire

// ===== bench/cvd_top_sva.sv
// cvd_top_sva: port checks for the data-valid, trigger and fill block.
// assumes one pixel clock and a synchronous reset.
`default_nettype none
module cvd_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic line_valid_i,
	input wire logic frame_valid_i,
	input wire logic [7:0] dma_data_i,
	input wire logic raster_go_o,
	input wire logic frame_go_o,
	input wire logic dma_read_o,
	input wire logic line_valid_o,
	input wire logic frame_valid_o,
	input wire logic data_valid_o,
	input wire logic [7:0] pix_data_o,
	input wire logic lamp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_out;
		!$past(rst_i);
	endsequence
	property p_ack;
		s_req |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_dat;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	a_dat: assert property (p_dat) else $error("read data off ack");
	property p_lv;
		s_out |-> line_valid_o == $past(line_valid_i);
	endproperty
	a_lv: assert property (p_lv) else $error("line valid moved");
	property p_fv;
		s_out |-> frame_valid_o == $past(frame_valid_i);
	endproperty
	a_fv: assert property (p_fv) else $error("frame valid moved");
	property p_dma;
		dma_read_o && !$past(rst_i) |-> pix_data_o == $past(dma_data_i);
	endproperty
	a_dma: assert property (p_dma) else $error("window pixel wrong");
	property p_pair;
		frame_go_o |-> raster_go_o;
	endproperty
	a_pair: assert property (p_pair) else $error("frame without raster");
	property p_lamp;
		$changed(lamp_o) |-> ack_o && $past(we_i);
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp moved alone");
	property p_rst;
		$past(rst_i) |-> !data_valid_o && !lamp_o && !raster_go_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live at reset");
endmodule
bind cvd_top cvd_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
	.ack_o, .line_valid_i, .frame_valid_i, .dma_data_i, .raster_go_o,
	.frame_go_o, .dma_read_o, .line_valid_o, .frame_valid_o,
	.data_valid_o, .pix_data_o, .lamp_o);
`default_nettype wire

// ===== bench/test_camera_video_dv_trigger_fill.sv
// test_camera_video_dv_trigger_fill: scenario bench for cvd_top.
// assumes a 16-clock line, line valid on hcnt 0..9.
`default_nettype none
module test_camera_video_dv_trigger_fill
	import cvd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic we_i = 1'b0, fire1 = 1'b0, fire2 = 1'b0, cc1, cc2, ack_o;
	logic raster_req_i = 1'b0, frame_req_i = 1'b0, raster_go_o;
	logic frame_go_o, dma_read_o, line_valid_o, frame_valid_o;
	logic data_valid_o, lamp_o;
	logic [31:0] adr_i = '0, dat_i = '0, dat_o, rd;
	logic [3:0] sel_i = 4'h3;
	logic [15:0] hcnt_i = 16'h0000, hp = 16'h0000;
	logic [7:0] pix_data_o;
	int mismatches = 0, n_compared = 0, cycles = 0, n0, n1;
	cvd_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .cc1_i(cc1), .cc2_i(cc2), .hcnt_i,
		.line_valid_i(hcnt_i < 16'h000a),
		.frame_valid_i(hcnt_i != 16'h000f),
		.raster_req_i, .frame_req_i, .dma_data_i(hcnt_i[7:0]),
		.raster_go_o, .frame_go_o, .dma_read_o, .line_valid_o,
		.frame_valid_o, .data_valid_o, .pix_data_o, .lamp_o);
	cvd_grabber_model link (.fire1_i(fire1), .fire2_i(fire2), .cc1_o(cc1),
		.cc2_o(cc2));
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		hcnt_i <= (hcnt_i == 16'h000f) ? 16'h0000 : hcnt_i + 16'h0001;
		hp <= hcnt_i;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] ix, input int d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {22'h0, ix, 2'b00};
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic at(input logic [15:0] h);
		do @(negedge clk_i); while (hp !== h);
	endtask
	task automatic pulse_raster();
		@(posedge clk_i);
		raster_req_i <= 1'b1;
		@(posedge clk_i);
		raster_req_i <= 1'b0;
	endtask
	task automatic t_regs();
		logic [7:0] ix [5] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h46};
		foreach (ix[i]) begin
			wb(0, ix[i], 0);
			cmp(rd, 0);
			wb(1, ix[i], 32'h5a);
			wb(0, ix[i], 0);
			cmp(rd, 32'h5a);
			wb(1, ix[i], 0);
		end
		wb(1, 8'h50, 32'hff);
		wb(0, 8'h50, 0);
		cmp(rd, 0);
		wb(1, IDX_TRIG_CFG, 32'h80);
		@(negedge clk_i);
		cmp(lamp_o, 1);
		wb(1, IDX_TRIG_CFG, 0);
	endtask
	task automatic t_dv(input int sk, input int pol);
		logic e;
		logic pat;
		wb(1, IDX_DV_CFG, sk * 16 + pol);
		at(16'h000f);
		repeat (16) begin
			@(negedge clk_i);
			pat = (hp % (sk + 1)) == 0;
			e = (pol == 3) ? 1'b0 : (hp < 10 || pol == 2) ? pat : pol == 1;
			cmp(data_valid_o, e);
		end
	endtask
	task automatic t_fill();
		wb(1, IDX_FILL_START, 32'ha5);
		wb(1, IDX_FILL_END, 32'h5a);
		wb(1, IDX_RW_START, 3);
		wb(1, IDX_RW_END, 7);
		wb(1, IDX_FILL_CTRL, 32'h20);
		// let a window close at its end position before judging a line
		at(16'h0008);
		at(16'h0001);
		cmp(pix_data_o, 32'ha5);
		cmp(dma_read_o, 0);
		at(16'h0005);
		cmp(pix_data_o, 5);
		cmp(dma_read_o, 1);
		at(16'h000c);
		cmp(pix_data_o, 32'h5a);
		cmp(dma_read_o, 0);
		wb(1, IDX_FILL_CTRL, 0);
		at(16'h0001);
		cmp(pix_data_o, 1);
		cmp(dma_read_o, 1);
		at(16'h000c);
		cmp(dma_read_o, 0);
	endtask
	task automatic t_raster(input int d, output int n);
		wb(1, IDX_TRIG_DLY, d);
		wb(1, IDX_TRIG_CFG, 1);
		pulse_raster();
		repeat (4) @(posedge clk_i);
		cmp(raster_go_o, 0);
		fire1 <= 1'b1;
		@(posedge cc1);
		n = 0;
		while (raster_go_o !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		fire1 <= 1'b0;
		repeat (20) @(posedge clk_i);
	endtask
	task automatic t_frame();
		logic seen;
		wb(1, IDX_TRIG_CFG, 0);
		pulse_raster();
		@(negedge clk_i);
		cmp(raster_go_o, 1);
		wb(1, IDX_TRIG_CFG, 32'h0e);
		@(posedge clk_i);
		frame_req_i <= 1'b1;
		@(posedge clk_i);
		frame_req_i <= 1'b0;
		fire2 <= 1'b1;
		@(posedge cc2);
		fire2 <= 1'b0;
		seen = 1'b0;
		while (cc2 === 1'b1) begin
			@(posedge clk_i);
			seen |= frame_go_o;
		end
		cmp(seen, 0);
		repeat (8) begin
			@(posedge clk_i);
			seen |= frame_go_o;
		end
		cmp(seen, 1);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		for (int s = 0; s < 8; s += 3)
			for (int p = 0; p < 4; p++)
				t_dv(s == 6 ? 7 : s, p);
		t_fill();
		t_raster(0, n0);
		t_raster(20, n1);
		cmp(32'(n1 - n0), 32'h14);
		cmp(32'(n0 inside {[9:12]}), 1);
		t_frame();
		stop_test();
	end
endmodule
`default_nettype wire

// ===== logic/cvd_pkg.sv
// cvd_pkg: constants shared by the camera video data-valid/trigger/fill block.
// assumes 32-bit classic wishbone with one register per aligned word.
`default_nettype none

package cvd_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_DV_CFG = 8'h41;
	localparam logic [7:0] IDX_TRIG_CFG = 8'h42;
	localparam logic [7:0] IDX_TRIG_DLY = 8'h43;
	localparam logic [7:0] IDX_FILL_START = 8'h44;
	localparam logic [7:0] IDX_FILL_CTRL = 8'h45;
	localparam logic [7:0] IDX_FILL_END = 8'h46;
	localparam logic [7:0] IDX_STATUS = 8'h47;
	localparam logic [7:0] IDX_LV_START = 8'h54;
	localparam logic [7:0] IDX_RW_START = 8'h58;
	localparam logic [7:0] IDX_RW_END = 8'h5a;
	localparam int ADR_LO = 2;
	localparam int ADR_HI = 9;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int SKIP_HI = 7;
	localparam int SKIP_LO = 4;
	localparam int POLICY_HI = 3;
	localparam int POLICY_LO = 0;
	localparam int LAMP_BIT = 7;
	localparam int INSEL_BIT = 3;
	localparam int EDGE_BIT = 2;
	localparam int FRAME_GATE_BIT = 1;
	localparam int RASTER_GATE_BIT = 0;
	localparam int FILL_EN_BIT = 5;

	// blanking_valid_policy codes
	localparam logic [3:0] POL_LOW = 4'h0;
	localparam logic [3:0] POL_HIGH = 4'h1;
	localparam logic [3:0] POL_SKIP = 4'h2;
	localparam logic [3:0] POL_OFF = 4'h3;

	// fixed pipeline latency added to the raster trigger delay
	localparam logic [8:0] PIPE_LAT = 9'h006;

	typedef enum logic [2:0] {
		CVD_IDLE = 3'b001,
		CVD_WAIT = 3'b010,
		CVD_DELAY = 3'b100
	} cvd_gate_e;

endpackage

`default_nettype wire

// ===== logic/cvd_sync.sv
// cvd_sync: two-flop synchroniser for one level from another domain.
// assumes the input is a pin; nothing but the second flop reads stage one.
`default_nettype none

module cvd_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule

`default_nettype wire

// ===== logic/cvd_top.sv
// cvd_top: data-valid strobe, trigger gating and margin fill for a
// simulated camera output, all on the pixel clock.
// assumes the horizontal/vertical timing generator on the same clock
// supplies hcnt, line/frame valid and raster/frame start requests.
//
// Local design decision: register access over Wishbone.
`default_nettype none

module cvd_top
	import cvd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic cc1_i,
	input wire logic cc2_i,
	input wire logic [15:0] hcnt_i,
	input wire logic line_valid_i,
	input wire logic frame_valid_i,
	input wire logic raster_req_i,
	input wire logic frame_req_i,
	input wire logic [7:0] dma_data_i,
	output logic raster_go_o,
	output logic frame_go_o,
	output logic dma_read_o,
	output logic line_valid_o,
	output logic frame_valid_o,
	output logic data_valid_o,
	output logic [7:0] pix_data_o,
	output logic lamp_o
);
	// ---------------------------------------------------------------
	// register bus
	// ---------------------------------------------------------------
	logic [7:0] dv_cfg_q, dv_cfg_d;
	logic [7:0] trig_cfg_q, trig_cfg_d;
	logic [7:0] trig_dly_q, trig_dly_d;
	logic [7:0] fill_start_q, fill_start_d;
	logic [7:0] fill_end_q, fill_end_d;
	logic [7:0] fill_ctrl_q, fill_ctrl_d;
	logic [15:0] lv_start_q, lv_start_d;
	logic [15:0] rw_start_q, rw_start_d;
	logic [15:0] rw_end_q, rw_end_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic [7:0] idx, status;
	logic wr, line_sel;
	cvd_gate_e gate_q, gate_d;
	assign idx = adr_i[ADR_HI:ADR_LO];
	assign wr = cyc_i && stb_i && we_i && !ack_q;
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction
	always_comb begin
		dv_cfg_d = dv_cfg_q;
		trig_cfg_d = trig_cfg_q;
		trig_dly_d = trig_dly_q;
		fill_start_d = fill_start_q;
		fill_end_d = fill_end_q;
		fill_ctrl_d = fill_ctrl_q;
		lv_start_d = lv_start_q;
		rw_start_d = rw_start_q;
		rw_end_d = rw_end_q;
		ack_d = cyc_i && stb_i && !ack_q;
		dat_d = 32'h0000_0000;
		if (wr && sel_i[0]) begin
			case (idx)
				IDX_DV_CFG: dv_cfg_d = dat_i[7:0];
				IDX_TRIG_CFG: trig_cfg_d = dat_i[7:0];
				IDX_TRIG_DLY: trig_dly_d = dat_i[7:0];
				IDX_FILL_START: fill_start_d = dat_i[7:0];
				IDX_FILL_END: fill_end_d = dat_i[7:0];
				IDX_FILL_CTRL: fill_ctrl_d = dat_i[7:0];
				default: ;
			endcase
		end
		if (wr) begin
			case (idx)
				IDX_LV_START: lv_start_d = merge16(lv_start_q, dat_i, sel_i);
				IDX_RW_START: rw_start_d = merge16(rw_start_q, dat_i, sel_i);
				IDX_RW_END: rw_end_d = merge16(rw_end_q, dat_i, sel_i);
				default: ;
			endcase
		end
		if (cyc_i && stb_i && !we_i && !ack_q) begin
			case (idx)
				IDX_DV_CFG: dat_d[7:0] = dv_cfg_q;
				IDX_TRIG_CFG: dat_d[7:0] = trig_cfg_q;
				IDX_TRIG_DLY: dat_d[7:0] = trig_dly_q;
				IDX_FILL_START: dat_d[7:0] = fill_start_q;
				IDX_FILL_END: dat_d[7:0] = fill_end_q;
				IDX_FILL_CTRL: dat_d[7:0] = fill_ctrl_q;
				IDX_STATUS: dat_d[7:0] = status;
				IDX_LV_START: dat_d[15:0] = lv_start_q;
				IDX_RW_START: dat_d[15:0] = rw_start_q;
				IDX_RW_END: dat_d[15:0] = rw_end_q;
				default: dat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dv_cfg_q <= RST_BYTE;
			trig_cfg_q <= RST_BYTE;
			trig_dly_q <= RST_BYTE;
			fill_start_q <= RST_BYTE;
			fill_end_q <= RST_BYTE;
			fill_ctrl_q <= RST_BYTE;
			lv_start_q <= RST_HALF;
			rw_start_q <= RST_HALF;
			rw_end_q <= RST_HALF;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			dv_cfg_q <= dv_cfg_d;
			trig_cfg_q <= trig_cfg_d;
			trig_dly_q <= trig_dly_d;
			fill_start_q <= fill_start_d;
			fill_end_q <= fill_end_d;
			fill_ctrl_q <= fill_ctrl_d;
			lv_start_q <= lv_start_d;
			rw_start_q <= rw_start_d;
			rw_end_q <= rw_end_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign lamp_o = trig_cfg_q[LAMP_BIT];

	// ---------------------------------------------------------------
	// trigger detection and start gating
	// ---------------------------------------------------------------
	logic cc1_s, cc2_s, trig_edge;
	logic prev_q, prev_d, is_frame_q, is_frame_d;
	logic raster_go_q, raster_go_d, frame_go_q, frame_go_d;
	logic [8:0] cnt_q, cnt_d;
	cvd_sync u_sync_cc1 (.clk_i(clk_i), .rst_i(rst_i), .async_i(cc1_i),
		.sync_o(cc1_s));
	cvd_sync u_sync_cc2 (.clk_i(clk_i), .rst_i(rst_i), .async_i(cc2_i),
		.sync_o(cc2_s));
	// a source switch can fake one edge; the gate only listens while waiting
	assign line_sel = trig_cfg_q[INSEL_BIT] ? cc2_s : cc1_s;
	assign trig_edge = trig_cfg_q[EDGE_BIT] ?
		(prev_q && !line_sel) : (!prev_q && line_sel);
	assign status = {5'h00, line_sel, gate_q == CVD_DELAY,
		gate_q == CVD_WAIT};

	always_comb begin
		prev_d = line_sel;
		gate_d = gate_q;
		cnt_d = cnt_q;
		is_frame_d = is_frame_q;
		raster_go_d = 1'b0;
		frame_go_d = 1'b0;
		case (gate_q)
			CVD_IDLE: begin
				// frame start takes precedence: it is also a raster start
				if (frame_req_i) begin
					if (trig_cfg_q[FRAME_GATE_BIT]) begin
						gate_d = CVD_WAIT;
						is_frame_d = 1'b1;
					end else if (trig_cfg_q[RASTER_GATE_BIT]) begin
						gate_d = CVD_WAIT;
						is_frame_d = 1'b1;
					end else begin
						frame_go_d = 1'b1;
						raster_go_d = 1'b1;
					end
				end else if (raster_req_i) begin
					if (trig_cfg_q[RASTER_GATE_BIT]) begin
						gate_d = CVD_WAIT;
						is_frame_d = 1'b0;
					end else begin
						raster_go_d = 1'b1;
					end
				end
			end
			CVD_WAIT: begin
				if (trig_edge) begin
					if (trig_cfg_q[RASTER_GATE_BIT]) begin
						// delay plus fixed pipeline latency
						cnt_d = {1'b0, trig_dly_q} + PIPE_LAT;
						gate_d = CVD_DELAY;
					end else begin
						frame_go_d = is_frame_q;
						raster_go_d = 1'b1;
						gate_d = CVD_IDLE;
					end
				end
			end
			CVD_DELAY: begin
				if (cnt_q <= 9'h001) begin
					frame_go_d = is_frame_q;
					raster_go_d = 1'b1;
					gate_d = CVD_IDLE;
				end else begin
					cnt_d = cnt_q - 9'h001;
				end
			end
			default: gate_d = CVD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_q <= CVD_IDLE;
			prev_q <= 1'b0;
			cnt_q <= 9'h000;
			is_frame_q <= 1'b0;
			raster_go_q <= 1'b0;
			frame_go_q <= 1'b0;
		end else begin
			gate_q <= gate_d;
			prev_q <= prev_d;
			cnt_q <= cnt_d;
			is_frame_q <= is_frame_d;
			raster_go_q <= raster_go_d;
			frame_go_q <= frame_go_d;
		end
	end

	assign raster_go_o = raster_go_q;
	assign frame_go_o = frame_go_q;

	// ---------------------------------------------------------------
	// data-valid strobe, read window and margin fill
	// ---------------------------------------------------------------
	logic [3:0] phase_q, phase_d, skip, policy;
	logic strobe, active, fill_en, read_win;
	logic win_q, win_d, opened_q, opened_d;
	logic lv_q, fv_q, dv_q, rd_q, dv_d;
	logic [7:0] pix_q, pix_d;
	assign skip = dv_cfg_q[SKIP_HI:SKIP_LO];
	assign policy = dv_cfg_q[POLICY_HI:POLICY_LO];
	assign fill_en = fill_ctrl_q[FILL_EN_BIT];
	assign active = line_valid_i && frame_valid_i;
	always_comb begin
		// phase zero at line start keeps strobe phase equal on every raster
		if (hcnt_i == lv_start_q)
			phase_d = 4'h0;
		else if (phase_q >= skip)
			phase_d = 4'h0;
		else
			phase_d = phase_q + 4'h1;
		strobe = (phase_d == 4'h0);
		case (policy)
			POL_LOW: dv_d = active && strobe;
			POL_HIGH: dv_d = active ? strobe : 1'b1;
			POL_SKIP: dv_d = strobe;
			POL_OFF: dv_d = 1'b0;
			default: dv_d = active && strobe;
		endcase
		win_d = win_q;
		if (hcnt_i == rw_start_q)
			win_d = 1'b1;
		else if (hcnt_i == rw_end_q)
			win_d = 1'b0;
		opened_d = opened_q;
		if (hcnt_i == lv_start_q)
			opened_d = 1'b0;
		if (hcnt_i == rw_start_q)
			opened_d = 1'b1;
		// current-cycle window so data lines up with line-valid
		read_win = fill_en ? win_d : line_valid_i;
		if (read_win)
			pix_d = dma_data_i;
		else if (opened_d)
			pix_d = fill_end_q;
		else
			pix_d = fill_start_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= 4'h0;
			win_q <= 1'b0;
			opened_q <= 1'b0;
			lv_q <= 1'b0;
			fv_q <= 1'b0;
			dv_q <= 1'b0;
			rd_q <= 1'b0;
			pix_q <= RST_BYTE;
		end else begin
			phase_q <= phase_d;
			win_q <= win_d;
			opened_q <= opened_d;
			// all video outputs share one stage, skip never retimes them
			lv_q <= line_valid_i;
			fv_q <= frame_valid_i;
			dv_q <= dv_d;
			rd_q <= read_win;
			pix_q <= pix_d;
		end
	end
	assign line_valid_o = lv_q;
	assign frame_valid_o = fv_q;
	assign data_valid_o = dv_q;
	assign dma_read_o = rd_q;
	assign pix_data_o = pix_q;
endmodule

`default_nettype wire
